/* File: sim/irqsrc_bench.sv */
// self-checking bench for the interrupt source block
`timescale 1ns/100ps
module irqsrc_bench;
  import irqsrc_pkg::*;
  logic core_clk = 1'b0, reset_n = 1'b0, clkEn = 1'b1, globalEnable = 1'b1;
  logic extIrqFirstN = 1'b1, extIrqSecondN = 1'b1, timerCExtTriggerN = 1'b1;
  logic extFirstTriggerType = 1'b0, extSecondTriggerType = 1'b0, adcTakeover = 1'b0;
  logic timerCExtTriggerEnable = 1'b0, usbRequest = 1'b0, serial1Request = 1'b0;
  logic serial2Request = 1'b0;
  logic [1:0] timerAMode = 2'h0;
  logic [9:0] srcEnable = 10'h3ff, srcPriority = 10'h000, flg;
  logic [11:0] ev = 12'h000;
  logic timerAOverflow, timerBOverflow, timerCOverflow, i2cSecondEvent, i2cFirstEvent;
  logic protocolSwitchEvent, adcDone, timerCFlagsClear, displayFlagsClear, take, finish;
  logic ddc1Event, vectorAck, serviceDone, irqValid, irqHigh, extFirstRequestFlag;
  logic extSecondRequestFlag, timerAOverflowFlag, timerBOverflowFlag, timerCOverflowFlag;
  logic timerCExtTriggerFlag, i2cSecondIntrFlag, i2cFirstIntrFlag, ddc1Flag;
  logic protocolSwitchFlag;
  logic [3:0] irqVector;
  int n_errors = 0, samples_checked = 0;
  // event pulses and core commands share one vector so one task drives them all
  assign {finish, take, displayFlagsClear, timerCFlagsClear, adcDone, protocolSwitchEvent,
    ddc1Event, i2cFirstEvent, i2cSecondEvent, timerCOverflow, timerBOverflow,
    timerAOverflow} = ev;
  assign flg = {extFirstRequestFlag, extSecondRequestFlag, timerAOverflowFlag,
    timerBOverflowFlag, timerCOverflowFlag, timerCExtTriggerFlag, i2cSecondIntrFlag,
    i2cFirstIntrFlag, ddc1Flag, protocolSwitchFlag};
  irqsrc_top u_irqsrc_top (.*);
  irqsrc_core_model u_irqsrc_core_model (.*);
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // one-cycle pulse; bit 10 takes the grant, bit 11 returns from the routine
  task automatic pulse(input int i);
    @(posedge core_clk) ev[i] <= 1'b1;
    @(posedge core_clk) ev[i] <= 1'b0;
    #1;
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // free-running core clock
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    complete_run();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    cyc(1);
    chk(flg, 10'h000);
    pulse(1);
    chk(flg, 10'h040);
    chk(10'(irqVector), 10'h006);
    pulse(10);
    chk(flg, 10'h000);
    pulse(11);
    @(posedge core_clk) timerAMode <= 2'h3;
    pulse(0);
    chk(flg, 10'h000);
    @(posedge core_clk) timerAMode <= 2'h0;
    pulse(0);
    chk(flg, 10'h080);
    pulse(10);
    chk(flg, 10'h000);
    pulse(11);
    pulse(2);
    pulse(10);
    pulse(11);
    chk(flg, 10'h020);
    pulse(8);
    chk(flg, 10'h000);
    // trigger pin ignored until enabled
    @(posedge core_clk) timerCExtTriggerN <= 1'b0;
    cyc(4);
    chk(flg, 10'h000);
    @(posedge core_clk) timerCExtTriggerN <= 1'b1;
    timerCExtTriggerEnable <= 1'b1;
    @(posedge core_clk) timerCExtTriggerN <= 1'b0;
    cyc(4);
    chk(flg, 10'h010);
    pulse(8);
    // one-cycle low on the first pin in edge mode
    @(posedge core_clk) extFirstTriggerType <= 1'b1;
    @(posedge core_clk) extIrqFirstN <= 1'b0;
    @(posedge core_clk) extIrqFirstN <= 1'b1;
    cyc(4);
    chk(flg, 10'h200);
    pulse(10);
    chk(flg, 10'h000);
    pulse(11);
    @(posedge core_clk) extFirstTriggerType <= 1'b0;
    @(posedge core_clk) extIrqFirstN <= 1'b0;
    cyc(4);
    pulse(10);
    chk(flg, 10'h200);
    @(posedge core_clk) extIrqFirstN <= 1'b1;
    cyc(4);
    pulse(11);
    chk(flg, 10'h000);
    @(posedge core_clk) extIrqSecondN <= 1'b0;
    cyc(4);
    chk(flg, 10'h100);
    @(posedge core_clk) extIrqSecondN <= 1'b1;
    adcTakeover <= 1'b1;
    cyc(4);
    // takeover makes the path edge type: vectoring clears the old level request
    pulse(10);
    pulse(11);
    chk(flg, 10'h000);
    pulse(7);
    chk(flg, 10'h100);
    pulse(10);
    chk(flg, 10'h000);
    pulse(11);
    // second pin in edge mode, converter released
    @(posedge core_clk) adcTakeover <= 1'b0;
    extSecondTriggerType <= 1'b1;
    @(posedge core_clk) extIrqSecondN <= 1'b0;
    cyc(4);
    chk(flg, 10'h100);
    pulse(10);
    @(posedge core_clk) extIrqSecondN <= 1'b1;
    cyc(4);
    chk(flg, 10'h000);
    pulse(11);
    pulse(3);
    chk(flg, 10'h008);
    pulse(10);
    chk(flg, 10'h000);
    pulse(11);
    for (int i = 4; i < 7; i++) pulse(i);
    chk(10'(irqVector), 10'h005);
    pulse(10);
    chk(flg, 10'h003);
    pulse(11);
    pulse(9);
    chk(flg, 10'h000);
    // high timer b preempts a low i2c routine, nested returns unwind in order
    @(posedge core_clk) srcPriority <= 10'h040;
    pulse(3);
    pulse(10);
    pulse(1);
    chk(10'({irqHigh, irqVector}), 10'h016);
    pulse(10);
    pulse(3);
    pulse(11);
    chk(10'(irqValid), 10'h000);
    pulse(11);
    chk(10'(irqVector), 10'h003);
    @(posedge core_clk) srcPriority <= 10'h000;
    pulse(1);
    chk(10'(irqVector), 10'h003);
    @(posedge core_clk) serial2Request <= 1'b1;
    cyc(1);
    chk(10'(irqVector), 10'h001);
    // a masked source drops out of the polling order
    @(posedge core_clk) srcEnable <= 10'h3fd;
    cyc(1);
    chk(10'(irqVector), 10'h003);
    // frozen clock enable swallows an overflow pulse
    @(posedge core_clk) clkEn <= 1'b0;
    pulse(2);
    @(posedge core_clk) clkEn <= 1'b1;
    cyc(1);
    chk(flg, 10'h048);
    // reset in mid-run clears every standing flag and the grant
    @(posedge core_clk) reset_n <= 1'b0;
    serial2Request <= 1'b0;
    timerCExtTriggerN <= 1'b1;
    cyc(2);
    chk(flg, 10'h000);
    chk(10'(irqValid), 10'h000);
    @(posedge core_clk) reset_n <= 1'b1;
    cyc(2);
    chk(flg, 10'h000);
    complete_run();
  end
endmodule // irqsrc_bench

/* File: sim/irqsrc_core_model.sv */
// behavioural core side: takes a grant and returns from the routine
`timescale 1ns/100ps
module irqsrc_core_model
  import irqsrc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic irqValid,
  input wire logic take,
  input wire logic finish,
  output logic vectorAck,
  output logic serviceDone
);
  // only a standing grant is taken; a held take simply waits, giving slow answers
  assign vectorAck = take & irqValid & reset_n;
  // returns come on command, after the bench has withdrawn level sources
  assign serviceDone = finish & reset_n;
endmodule // irqsrc_core_model

/* File: sim/irqsrc_top_monitor.sv */
// port-level checks of the interrupt source block
`timescale 1ns/100ps
module irqsrc_top_monitor
  import irqsrc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic extIrqFirstN,
  input wire logic extFirstTriggerType,
  input wire logic timerAOverflow,
  input wire logic [1:0] timerAMode,
  input wire logic timerBOverflow,
  input wire logic timerCFlagsClear,
  input wire logic i2cSecondEvent,
  input wire logic displayFlagsClear,
  input wire logic [NumSrc-1:0] srcEnable,
  input wire logic [NumSrc-1:0] srcPriority,
  input wire logic vectorAck,
  input wire logic irqValid,
  input wire logic irqHigh,
  input wire logic [VecW-1:0] irqVector,
  input wire logic extFirstRequestFlag,
  input wire logic timerAOverflowFlag,
  input wire logic timerBOverflowFlag,
  input wire logic timerCOverflowFlag,
  input wire logic i2cSecondIntrFlag,
  input wire logic ddc1Flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  chk_timer_a_set:
    assert property (clkEn && timerAOverflow && timerAMode != TimerModeSplit
      |=> timerAOverflowFlag) else $error("timer a flag missed");
  chk_split_mode_block:
    assert property (clkEn && timerAMode == TimerModeSplit && !timerAOverflowFlag
      |=> !timerAOverflowFlag) else $error("timer a flag set in split mode");
  chk_timer_b_clear:
    assert property (clkEn && vectorAck && irqVector == SrcTimerB && !timerBOverflow
      |=> !timerBOverflowFlag) else $error("timer b flag kept");
  chk_timer_c_hold:
    assert property (clkEn && timerCOverflowFlag && !timerCFlagsClear
      |=> timerCOverflowFlag) else $error("timer c flag lost");
  chk_i2c_set:
    assert property (clkEn && i2cSecondEvent |=> i2cSecondIntrFlag)
      else $error("i2c flag missed");
  chk_display_soft_hold:
    assert property (clkEn && ddc1Flag && !displayFlagsClear |=> ddc1Flag)
      else $error("display flag lost");
  chk_level_follow:
    assert property ((clkEn && !extFirstTriggerType && !extIrqFirstN)[*4]
      |-> extFirstRequestFlag) else $error("level flag not following pin");
  chk_high_wins:
    assert property (irqValid && timerBOverflowFlag && srcEnable[SrcTimerB]
      && srcPriority[SrcTimerB] |-> irqHigh) else $error("high request not chosen");
  cover property (vectorAck && irqHigh);
  cover property (vectorAck && irqVector == SrcExtFirst);
  cover property (ddc1Flag && displayFlagsClear);
endmodule // irqsrc_top_monitor

bind irqsrc_top irqsrc_top_monitor u_irqsrc_top_monitor (.*);

/* File: verilog/irqsrc_arbiter.sv */
// priority and polling arbiter with in-service tracking
`timescale 1ns/100ps
module irqsrc_arbiter
  import irqsrc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic globalEn,
  input wire logic vectorAck,
  input wire logic serviceDone,
  irqsrc_sel_if.arb sel
);
  irqsrc_level_t level_r;
  logic [VecW-1:0] hiVec;
  logic [VecW-1:0] loVec;
  logic hiAny;
  logic loAny;
  // lowest index wins within a level
  always_comb begin
    hiVec = '0;
    loVec = '0;
    hiAny = 1'b0;
    loAny = 1'b0;
    for (int i = NumSrc - 1; i >= 0; i--) begin
      if (sel.pend[i] && sel.prio[i] == PrioHigh) begin
        hiAny = 1'b1;
        hiVec = VecW'(i);
      end
      if (sel.pend[i] && sel.prio[i] != PrioHigh) begin
        loAny = 1'b1;
        loVec = VecW'(i);
      end
    end
  end
  // nothing preempts high; high preempts low only
  always_comb begin
    sel.grantValid = 1'b0;
    sel.grantHigh = 1'b0;
    sel.grantVec = hiVec;
    if (globalEn) begin
      if (hiAny && level_r != IRQSRC_HIGH && level_r != IRQSRC_BOTH) begin
        sel.grantValid = 1'b1;
        sel.grantHigh = 1'b1;
      end else if (loAny && level_r == IRQSRC_IDLE) begin
        sel.grantValid = 1'b1;
        sel.grantVec = loVec;
      end
    end
  end
  // in-service levels; return closes the highest active level
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      level_r <= IRQSRC_IDLE;
    end else if (clkEn) begin
      if (vectorAck && sel.grantValid) begin
        case (level_r)
          IRQSRC_IDLE: level_r <= sel.grantHigh ? IRQSRC_HIGH : IRQSRC_LOW;
          IRQSRC_LOW: level_r <= IRQSRC_BOTH;
          default: level_r <= level_r;
        endcase
      end else if (serviceDone) begin
        case (level_r)
          IRQSRC_BOTH: level_r <= IRQSRC_LOW;
          IRQSRC_LOW: level_r <= IRQSRC_IDLE;
          IRQSRC_HIGH: level_r <= IRQSRC_IDLE;
          default: level_r <= IRQSRC_IDLE;
        endcase
      end
    end
  end
endmodule // irqsrc_arbiter

/* File: verilog/irqsrc_edge_sync.sv */
// two-stage synchroniser with edge detect for the external request pins
`timescale 1ns/100ps
module irqsrc_edge_sync
  import irqsrc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [1:0] pinIn,
  output logic [1:0] pinLevel,
  output logic [1:0] pinFall
);
  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic [1:0] prev_r;
  // first stage read only by the second stage
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 2'h3;
      sync_r <= 2'h3;
      prev_r <= 2'h3;
    end else if (clkEn) begin
      meta_r <= pinIn;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  // pins are active low; a fall between consecutive samples is an edge
  assign pinLevel = ~sync_r;
  assign pinFall = prev_r & ~sync_r;
endmodule // irqsrc_edge_sync

/* File: verilog/irqsrc_pkg.sv */
// constants and types shared by the interrupt request source block
package irqsrc_pkg;
  localparam int NumSrc = 10;
  localparam int VecW = 4;
  // polling order, index 0 polled first
  localparam logic [3:0] SrcExtFirst = 4'h0;
  localparam logic [3:0] SrcSerial2 = 4'h1;
  localparam logic [3:0] SrcTimerA = 4'h2;
  localparam logic [3:0] SrcI2c = 4'h3;
  localparam logic [3:0] SrcExtSecond = 4'h4;
  localparam logic [3:0] SrcDisplay = 4'h5;
  localparam logic [3:0] SrcTimerB = 4'h6;
  localparam logic [3:0] SrcUsb = 4'h7;
  localparam logic [3:0] SrcSerial1 = 4'h8;
  localparam logic [3:0] SrcTimerC = 4'h9;
  localparam logic [1:0] TimerModeSplit = 2'h3;
  localparam logic PrioHigh = 1'b1;
  typedef enum logic [1:0] {
    IRQSRC_IDLE = 2'b00,
    IRQSRC_LOW = 2'b01,
    IRQSRC_HIGH = 2'b10,
    IRQSRC_BOTH = 2'b11
  } irqsrc_level_t;
endpackage

/* File: verilog/irqsrc_sel_if.sv */
// request and priority bundle between the flag logic and the arbiter
`timescale 1ns/100ps
interface irqsrc_sel_if;
  import irqsrc_pkg::*;
  logic [NumSrc-1:0] pend;
  logic [NumSrc-1:0] prio;
  logic grantValid;
  logic grantHigh;
  logic [VecW-1:0] grantVec;
  modport flags (output pend, output prio, input grantValid, input grantHigh, input grantVec);
  modport arb (input pend, input prio, output grantValid, output grantHigh, output grantVec);
endinterface

/* File: verilog/irqsrc_top.sv */
// interrupt request flags for ten sources with priority selection
`timescale 1ns/100ps
module irqsrc_top
  import irqsrc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic extIrqFirstN,
  input wire logic extIrqSecondN,
  input wire logic extFirstTriggerType,
  input wire logic extSecondTriggerType,
  input wire logic adcTakeover,
  input wire logic adcDone,
  input wire logic timerAOverflow,
  input wire logic [1:0] timerAMode,
  input wire logic timerBOverflow,
  input wire logic timerCOverflow,
  input wire logic timerCExtTriggerN,
  input wire logic timerCExtTriggerEnable,
  input wire logic timerCFlagsClear,
  input wire logic i2cSecondEvent,
  input wire logic i2cFirstEvent,
  input wire logic ddc1Event,
  input wire logic protocolSwitchEvent,
  input wire logic displayFlagsClear,
  input wire logic usbRequest,
  input wire logic serial1Request,
  input wire logic serial2Request,
  input wire logic [NumSrc-1:0] srcEnable,
  input wire logic [NumSrc-1:0] srcPriority,
  input wire logic globalEnable,
  input wire logic vectorAck,
  input wire logic serviceDone,
  output logic irqValid,
  output logic irqHigh,
  output logic [VecW-1:0] irqVector,
  output logic extFirstRequestFlag,
  output logic extSecondRequestFlag,
  output logic timerAOverflowFlag,
  output logic timerBOverflowFlag,
  output logic timerCOverflowFlag,
  output logic timerCExtTriggerFlag,
  output logic i2cSecondIntrFlag,
  output logic i2cFirstIntrFlag,
  output logic ddc1Flag,
  output logic protocolSwitchFlag
);
  // carrier between the flag logic and the arbiter
  irqsrc_sel_if sel ();

  // synchronised pin views
  logic [1:0] pinLevel;
  logic [1:0] pinFall;

  // requests before masking, and one service strobe per source
  logic [NumSrc-1:0] raw;
  logic [NumSrc-1:0] taken;

  // registered request flags, reset to no request
  logic extFirst_r;
  logic extSecond_r;
  logic timerA_r;
  logic timerB_r;
  logic timerC_r;
  logic timerCExt_r;
  logic i2cSecond_r;
  logic i2cFirst_r;
  logic ddc1_r;
  logic swh_r;

  // second external path after the converter takeover choice
  logic secondLevel;
  logic secondEdge;
  logic secondIsEdge;

  // pins pass two flops before any flag logic sees them
  irqsrc_edge_sync u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .pinIn({extIrqSecondN, extIrqFirstN}),
    .pinLevel(pinLevel),
    .pinFall(pinFall)
  );

  // the trigger pin of timer c shares the sampled path through a second instance
  logic [1:0] trigLevel;
  logic [1:0] trigFall;
  // the spare second channel is tied idle so it never shows an edge
  irqsrc_edge_sync u_trig (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .pinIn({1'b1, timerCExtTriggerN}),
    .pinLevel(trigLevel),
    .pinFall(trigFall)
  );

  // one-cycle service strobe per source from the arbiter grant
  always_comb begin
    taken = '0;
    // an acknowledge without a standing grant strobes nothing
    if (vectorAck && sel.grantValid) begin
      taken[sel.grantVec] = 1'b1;
    end
  end

  // converter takeover swaps the second path for conversion done, as an edge
  assign secondIsEdge = adcTakeover | extSecondTriggerType;
  // the level view is parked low once the converter owns the path
  assign secondLevel = adcTakeover ? 1'b0 : pinLevel[1];
  assign secondEdge = adcTakeover ? adcDone : pinFall[1];

  // first external flag; set wins over the vectoring clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      extFirst_r <= 1'b0;
    end else if (clkEn) begin
      // level mode mirrors the pin, so vectoring has nothing to clear
      if (!extFirstTriggerType) begin
        extFirst_r <= pinLevel[0];
      end else if (pinFall[0]) begin
        extFirst_r <= 1'b1;
      end else if (taken[SrcExtFirst]) begin
        extFirst_r <= 1'b0;
      end
    end
  end

  // second external flag, pin or converter
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      extSecond_r <= 1'b0;
    end else if (clkEn) begin
      // converter takeover always counts as edge mode
      if (!secondIsEdge) begin
        extSecond_r <= secondLevel;
      end else if (secondEdge) begin
        extSecond_r <= 1'b1;
      end else if (taken[SrcExtSecond]) begin
        extSecond_r <= 1'b0;
      end
    end
  end

  // timer a overflow flag, cleared when serviced
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      timerA_r <= 1'b0;
    end else if (clkEn) begin
      // split mode routes timer a overflow elsewhere, so it sets nothing here
      if (timerAOverflow && timerAMode != TimerModeSplit) begin
        timerA_r <= 1'b1;
      end else if (taken[SrcTimerA]) begin
        timerA_r <= 1'b0;
      end
    end
  end

  // timer b overflow flag, cleared when serviced
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      timerB_r <= 1'b0;
    end else if (clkEn) begin
      // no split mode here, so every overflow raises the request
      if (timerBOverflow) begin
        timerB_r <= 1'b1;
      end else if (taken[SrcTimerB]) begin
        timerB_r <= 1'b0;
      end
    end
  end

  // timer c overflow flag, software clear only
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      timerC_r <= 1'b0;
    end else if (clkEn) begin
      // vectoring leaves it, so the routine can still tell its two causes apart
      if (timerCOverflow) begin
        timerC_r <= 1'b1;
      end else if (timerCFlagsClear) begin
        timerC_r <= 1'b0;
      end
    end
  end

  // timer c trigger flag, same software clear as the overflow flag
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      timerCExt_r <= 1'b0;
    end else if (clkEn) begin
      // the enable gates only the set; a standing flag survives disabling
      if (trigFall[0] && timerCExtTriggerEnable) begin
        timerCExt_r <= 1'b1;
      end else if (timerCFlagsClear) begin
        timerCExt_r <= 1'b0;
      end
    end
  end

  // second i2c interrupt bit, hardware clears on service
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      i2cSecond_r <= 1'b0;
    end else if (clkEn) begin
      // a new event in the vectoring cycle wins, so no transfer is lost
      if (i2cSecondEvent) begin
        i2cSecond_r <= 1'b1;
      end else if (taken[SrcI2c]) begin
        i2cSecond_r <= 1'b0;
      end
    end
  end

  // first i2c interrupt bit, the one display channel bit hardware clears
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      i2cFirst_r <= 1'b0;
    end else if (clkEn) begin
      // cleared only when the display source itself is vectored
      if (i2cFirstEvent) begin
        i2cFirst_r <= 1'b1;
      end else if (taken[SrcDisplay]) begin
        i2cFirst_r <= 1'b0;
      end
    end
  end

  // first display channel flag, only software clears it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ddc1_r <= 1'b0;
    end else if (clkEn) begin
      // vectoring leaves it; the routine reads it to find the cause
      if (ddc1Event) begin
        ddc1_r <= 1'b1;
      end else if (displayFlagsClear) begin
        ddc1_r <= 1'b0;
      end
    end
  end

  // protocol switch flag, only software clears it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      swh_r <= 1'b0;
    end else if (clkEn) begin
      // set by the one-way switch of protocol, held through vectoring
      if (protocolSwitchEvent) begin
        swh_r <= 1'b1;
      end else if (displayFlagsClear) begin
        swh_r <= 1'b0;
      end
    end
  end

  // raw requests in polling order; usb and serial flags live in their units
  always_comb begin
    raw = '0;
    raw[SrcExtFirst] = extFirst_r;
    raw[SrcSerial2] = serial2Request;
    raw[SrcTimerA] = timerA_r;
    raw[SrcI2c] = i2cSecond_r;
    raw[SrcExtSecond] = extSecond_r;
    raw[SrcDisplay] = i2cFirst_r | ddc1_r | swh_r;
    raw[SrcTimerB] = timerB_r;
    raw[SrcUsb] = usbRequest;
    raw[SrcSerial1] = serial1Request;
    raw[SrcTimerC] = timerC_r | timerCExt_r;
  end

  // per-source enables mask requests before arbitration
  assign sel.pend = raw & srcEnable;
  assign sel.prio = srcPriority;

  // a level source must drop before serviceDone or it is taken again
  // the arbiter keeps the in-service levels; this module only keeps flags
  irqsrc_arbiter u_arb (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .globalEn(globalEnable),
    .vectorAck(vectorAck),
    .serviceDone(serviceDone),
    .sel(sel)
  );

  // grant stays combinational so the core can acknowledge in the same cycle
  assign irqValid = sel.grantValid;
  assign irqHigh = sel.grantHigh;
  assign irqVector = sel.grantVec;

  // flags straight from their flops
  assign extFirstRequestFlag = extFirst_r;
  assign extSecondRequestFlag = extSecond_r;
  assign timerAOverflowFlag = timerA_r;
  assign timerBOverflowFlag = timerB_r;
  assign timerCOverflowFlag = timerC_r;
  assign timerCExtTriggerFlag = timerCExt_r;
  assign i2cSecondIntrFlag = i2cSecond_r;
  assign i2cFirstIntrFlag = i2cFirst_r;
  assign ddc1Flag = ddc1_r;
  assign protocolSwitchFlag = swh_r;
endmodule // irqsrc_top
